// *** core/adcsq_pkg.sv ***
// adcsq_pkg: register map, field layout and timing for the converter sequencer.
// assumes a byte-wide register port with one-cycle read latency.
package adcsq_pkg;
  // register byte offsets
  localparam logic [7:0] ADCSQ_OFF_STATUS_CTRL = 8'h38;
  localparam logic [7:0] ADCSQ_OFF_RESULT      = 8'h39;
  localparam logic [7:0] ADCSQ_OFF_CLOCK_CFG   = 8'h3A;
  // status_control_reg fields
  localparam int ADCSQ_BIT_COMPLETE   = 7;
  localparam int ADCSQ_BIT_IRQ_EN     = 6;
  localparam int ADCSQ_BIT_CONTINUOUS = 5;
  localparam int ADCSQ_CH_MSB         = 4;
  // clock_cfg fields
  localparam int ADCSQ_DIV_MSB        = 7;
  localparam int ADCSQ_DIV_LSB        = 5;
  localparam int ADCSQ_BIT_CLK_SRC    = 4;
  // channel codes
  localparam logic [4:0] ADCSQ_CH_LAST     = 5'h0E;
  localparam logic [4:0] ADCSQ_CH_REF_HIGH = 5'h1D;
  localparam logic [4:0] ADCSQ_CH_REF_LOW  = 5'h1E;
  localparam logic [4:0] ADCSQ_CH_OFF      = 5'h1F;
  localparam int         ADCSQ_NUM_PINS    = 15;
  // result codes at the references
  localparam logic [7:0] ADCSQ_CODE_FULL   = 8'hFF;
  localparam logic [7:0] ADCSQ_CODE_ZERO   = 8'h00;
  // timing: eight sample ticks plus eight bit trials, in converter clocks
  localparam logic [4:0] ADCSQ_CONV_CYCLES = 5'h10;
  localparam logic [3:0] ADCSQ_PRESC_MAX   = 4'hF;
  // reset values
  localparam logic [4:0] ADCSQ_RST_CH      = 5'h1F;
  localparam logic [2:0] ADCSQ_RST_DIV     = 3'h0;
endpackage : adcsq_pkg

// *** core/adcsq_top.sv ***
// adcsq_top: sequencer for an 8-bit successive approximation converter.
// assumes an external comparator answering analog input >= trial code,
// port logic outside honouring the pin takeover outputs.
//
// Contract
// - write to control starts 16-17 clock conversion
// - end latches result, sets flag or irq
// - 8-bit result, references give FF/00
// - selected pin forced to converter input
// - port writes ignored on selected pin
// - read of selected pin: 0 or latch
// - continuous mode overwrites result every conversion
// - continuous conversions run until bit cleared
// - flag read-only, sticky, cleared by write/read while irq disabled; a write with irq enable set loads it
// - irq enabled: flag bit gates cpu interrupt
// - result read or control write clears irq
// - reset clears flag, irq enable, continuous
// - single mode converts exactly once per start
// - wait mode keeps converting, irq wakes
// - stop aborts conversion, no restart until next control write
// - 5-bit channel decode incl. references
// - all-ones channel powers off; reset sets
// - 3-bit prescaler /1 /2 /4 /8 /16
// - clock source bit picks bus or crystal
`timescale 1ns/1ps
module adcsq_top
  import adcsq_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  // register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  // system
  input  wire logic        crystal_clock_in,
  input  wire logic        stop_mode_in,
  output logic             conv_irq_out,
  // analog front end
  input  wire logic        comparator_in,
  output logic      [7:0]  trial_code_out,
  output logic      [4:0]  selected_analog_input_out,
  output logic             sample_out,
  output logic             analog_power_out,
  // shared port pins
  input  wire logic [14:0] port_data_latch_in,
  input  wire logic [14:0] port_dir_in,
  input  wire logic [14:0] port_pin_in,
  output logic      [14:0] pin_takeover_out,
  output logic      [14:0] port_read_out
);

  // prescaler end counts for /1 /2 /4 /8
  localparam logic [3:0] ADCSQ_LIM_DIV1    = 4'h0;
  localparam logic [3:0] ADCSQ_LIM_DIV2    = 4'h1;
  localparam logic [3:0] ADCSQ_LIM_DIV4    = 4'h3;
  localparam logic [3:0] ADCSQ_LIM_DIV8    = 4'h7;
  // first trial code and its bit index
  localparam logic [7:0] ADCSQ_TRIAL_FIRST = 8'h80;
  localparam logic [2:0] ADCSQ_BIT_TOP     = 3'h7;
  // sample ticks pad eight trials out to the full conversion length
  localparam logic [3:0] ADCSQ_SAMPLE_LAST = 4'(ADCSQ_CONV_CYCLES - 5'h09);

  typedef enum logic [2:0] {
    ADCSQ_IDLE   = 3'b001,
    ADCSQ_SAMPLE = 3'b010,
    ADCSQ_TRIAL  = 3'b100
  } adcsq_state_t;

  function automatic logic [14:0] adcsq_pin_mask(input logic [4:0] ch);
    logic [14:0] m;
    m = '0;
    if (ch <= ADCSQ_CH_LAST) begin
      m[ch[3:0]] = 1'b1;
    end
    return m;
  endfunction : adcsq_pin_mask

  adcsq_state_t state_r;
  logic         complete_r;
  logic         irq_en_r;
  logic         cont_r;
  logic [4:0]   ch_r;
  logic [2:0]   div_r;
  logic         clk_src_r;
  logic [7:0]   result_r;
  logic [7:0]   sar_r;
  logic [2:0]   bit_idx_r;
  logic         irq_pend_r;
  logic [3:0]   presc_r;
  logic [3:0]   samp_cnt_r;
  logic         conv_tick_r;
  logic         xtal_meta_r;
  logic         xtal_sync_r;
  logic         xtal_prev_r;
  logic         stop_meta_r;
  logic         stop_sync_r;
  logic         cmp_meta_r;
  logic         cmp_sync_r;
  logic [14:0]  pin_meta_r;
  logic [14:0]  pin_sync_r;

  logic         wr_ctrl;
  logic         rd_result;
  logic         src_tick;
  logic [3:0]   presc_lim;
  logic         conv_done;
  logic [7:0]   sar_final;
  logic         ch_pin;
  logic [14:0]  sel_mask;
  logic         samp_last;

  assign wr_ctrl   = reg_wr_in && (reg_addr_in == ADCSQ_OFF_STATUS_CTRL);
  assign rd_result = reg_rd_in && (reg_addr_in == ADCSQ_OFF_RESULT);
  assign ch_pin    = (ch_r <= ADCSQ_CH_LAST);
  assign sel_mask  = adcsq_pin_mask(ch_r);
  assign samp_last = (samp_cnt_r == ADCSQ_SAMPLE_LAST);

  // synchronisers for outside inputs
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      xtal_meta_r <= 1'b0;
      xtal_sync_r <= 1'b0;
      xtal_prev_r <= 1'b0;
      stop_meta_r <= 1'b0;
      stop_sync_r <= 1'b0;
      cmp_meta_r  <= 1'b0;
      cmp_sync_r  <= 1'b0;
      pin_meta_r  <= '0;
      pin_sync_r  <= '0;
    end else begin
      xtal_meta_r <= crystal_clock_in;
      xtal_sync_r <= xtal_meta_r;
      xtal_prev_r <= xtal_sync_r;
      stop_meta_r <= stop_mode_in;
      stop_sync_r <= stop_meta_r;
      cmp_meta_r  <= comparator_in;
      cmp_sync_r  <= cmp_meta_r;
      pin_meta_r  <= port_pin_in;
      pin_sync_r  <= pin_meta_r;
    end
  end

  // crystal rising edges found after the synchroniser, one tick each
  // source select
  assign src_tick = clk_src_r ? 1'b1 : (xtal_sync_r && !xtal_prev_r);

  // bus source at /1 or /2 outruns the three-cycle comparator path
  // prescaler decode
  always_comb begin
    unique casez (div_r)
      3'b000:  presc_lim = ADCSQ_LIM_DIV1;
      3'b001:  presc_lim = ADCSQ_LIM_DIV2;
      3'b010:  presc_lim = ADCSQ_LIM_DIV4;
      3'b011:  presc_lim = ADCSQ_LIM_DIV8;
      default: presc_lim = ADCSQ_PRESC_MAX;
    endcase
  end

  // converter clock enable; idles while powered off or stopped
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      presc_r     <= 4'h0;
      conv_tick_r <= 1'b0;
    end else if (stop_sync_r || ch_r == ADCSQ_CH_OFF || wr_ctrl) begin
      presc_r     <= 4'h0;
      conv_tick_r <= 1'b0;
    end else begin
      conv_tick_r <= 1'b0;
      if (src_tick) begin
        if (presc_r >= presc_lim) begin
          presc_r     <= 4'h0;
          conv_tick_r <= 1'b1;
        end else begin
          presc_r <= presc_r + 4'h1;
        end
      end
    end
  end

  // counts sample ticks; restarts with every new conversion
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      samp_cnt_r <= 4'h0;
    end else if (stop_sync_r || wr_ctrl || state_r != ADCSQ_SAMPLE) begin
      samp_cnt_r <= 4'h0;
    end else if (conv_tick_r) begin
      samp_cnt_r <= samp_cnt_r + 4'h1;
    end
  end

  // last trial bit settles the 8-bit code
  assign sar_final = cmp_sync_r ? sar_r : (sar_r & ~(8'h01 << bit_idx_r));
  // done on the last trial tick; same edge latches the result
  assign conv_done = (state_r == ADCSQ_TRIAL) && conv_tick_r && (bit_idx_r == 3'h0);

  // conversion sequencer
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      state_r   <= ADCSQ_IDLE;
      sar_r     <= ADCSQ_CODE_ZERO;
      bit_idx_r <= ADCSQ_BIT_TOP;
    end else if (stop_sync_r) begin
      state_r <= ADCSQ_IDLE;
    end else if (wr_ctrl) begin
      state_r   <= (reg_wdata_in[ADCSQ_CH_MSB:0] == ADCSQ_CH_OFF) ? ADCSQ_IDLE : ADCSQ_SAMPLE;
      sar_r     <= ADCSQ_TRIAL_FIRST;
      bit_idx_r <= ADCSQ_BIT_TOP;
    end else if (conv_tick_r) begin
      unique case (state_r)
        ADCSQ_IDLE: begin
          state_r <= ADCSQ_IDLE;
        end
        ADCSQ_SAMPLE: begin
          // eight trials follow the padded sample phase
          state_r <= samp_last ? ADCSQ_TRIAL : ADCSQ_SAMPLE;
        end
        ADCSQ_TRIAL: begin
          if (bit_idx_r == 3'h0) begin
            state_r   <= cont_r ? ADCSQ_SAMPLE : ADCSQ_IDLE;
            sar_r     <= ADCSQ_TRIAL_FIRST;
            bit_idx_r <= ADCSQ_BIT_TOP;
          end else begin
            sar_r     <= sar_final | (ADCSQ_TRIAL_FIRST >> (4'h8 - {1'b0, bit_idx_r}));
            bit_idx_r <= bit_idx_r - 3'h1;
          end
        end
        default: begin
          state_r <= ADCSQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      result_r <= ADCSQ_CODE_ZERO;
    end else if (conv_done) begin
      // no read handshake; unread results are lost
      result_r <= sar_final;
    end
  end

  // control fields
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      irq_en_r  <= 1'b0;
      cont_r    <= 1'b0;
      ch_r      <= ADCSQ_RST_CH;
      div_r     <= ADCSQ_RST_DIV;
      clk_src_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        irq_en_r <= reg_wdata_in[ADCSQ_BIT_IRQ_EN];
        cont_r   <= reg_wdata_in[ADCSQ_BIT_CONTINUOUS];
        ch_r     <= reg_wdata_in[ADCSQ_CH_MSB:0];
      end
      // clock fields; changing them mid-conversion spoils that result
      if (reg_wr_in && reg_addr_in == ADCSQ_OFF_CLOCK_CFG) begin
        div_r     <= reg_wdata_in[ADCSQ_DIV_MSB:ADCSQ_DIV_LSB];
        clk_src_r <= reg_wdata_in[ADCSQ_BIT_CLK_SRC];
      end
    end
  end

  // complete flag; a conversion end wins over a clear
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      complete_r <= 1'b0;
    end else if (conv_done && !irq_en_r) begin
      complete_r <= 1'b1;
    end else if (wr_ctrl) begin
      complete_r <= reg_wdata_in[ADCSQ_BIT_IRQ_EN] ? reg_wdata_in[ADCSQ_BIT_COMPLETE] : 1'b0;
    end else if (rd_result && !irq_en_r) begin
      complete_r <= 1'b0;
    end
  end

  // irq pending; set beats clear
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      irq_pend_r <= 1'b0;
    end else if (conv_done && irq_en_r && !complete_r) begin
      // raise when service bit is 0
      irq_pend_r <= 1'b1;
    end else if (wr_ctrl || rd_result) begin
      irq_pend_r <= 1'b0;
    end
  end

  // read port and outputs
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out             <= 8'h00;
      conv_irq_out              <= 1'b0;
      trial_code_out            <= ADCSQ_CODE_ZERO;
      selected_analog_input_out <= ADCSQ_RST_CH;
      sample_out                <= 1'b0;
      analog_power_out          <= 1'b0;
      pin_takeover_out          <= '0;
      port_read_out             <= '0;
    end else begin
      reg_rdata_out <= 8'h00;
      if (reg_rd_in) begin
        unique case (reg_addr_in)
          ADCSQ_OFF_STATUS_CTRL: reg_rdata_out <= {complete_r, irq_en_r, cont_r, ch_r};
          ADCSQ_OFF_RESULT:      reg_rdata_out <= result_r;
          ADCSQ_OFF_CLOCK_CFG:   reg_rdata_out <= {div_r, clk_src_r, 4'h0};
          default:               reg_rdata_out <= 8'h00;
        endcase
      end
      // request stays up to wake a waiting cpu
      conv_irq_out              <= irq_pend_r;
      trial_code_out            <= sar_r;
      // channel passed on to the analog mux
      selected_analog_input_out <= ch_r;
      sample_out                <= (state_r == ADCSQ_SAMPLE);
      analog_power_out          <= (ch_r != ADCSQ_CH_OFF) && !stop_sync_r;
      pin_takeover_out          <= ch_pin ? sel_mask : '0;
      // selected pin reads 0 or the latch
      port_read_out             <= ch_pin ? ((pin_sync_r & ~sel_mask) |
                                             (port_data_latch_in & port_dir_in & sel_mask))
                                          : pin_sync_r;
    end
  end

endmodule : adcsq_top

// *** tb/adcsq_chk_sva.sv ***
// checker: pin takeover, power, request clear and start relations
// assumes binding to adcsq_top, sees only its ports
`timescale 1ns/1ps
module adcsq_chk
  import adcsq_pkg::*;
(
  // watched ports
  input wire logic        clk_sys_in,
  input wire logic        reset_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic        stop_mode_in,
  input wire logic        conv_irq_out,
  input wire logic [4:0]  selected_analog_input_out,
  input wire logic        sample_out,
  input wire logic        analog_power_out,
  input wire logic [14:0] pin_takeover_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  sequence s_ctl_wr;
    reg_wr_in && reg_addr_in == ADCSQ_OFF_STATUS_CTRL;
  endsequence
  sequence s_res_rd;
    reg_rd_in && reg_addr_in == ADCSQ_OFF_RESULT;
  endsequence
  AST_TAKE_ONEHOT: assert property ($onehot0(pin_takeover_out))
    else $error("takeover on several pins");
  AST_TAKE_CH: assert property (
    (analog_power_out && selected_analog_input_out <= ADCSQ_CH_LAST
     && $stable(selected_analog_input_out)) [*2]
    |-> pin_takeover_out == (15'h0001 << selected_analog_input_out))
    else $error("takeover not on selected pin");
  AST_PWR_OFF: assert property (
    (selected_analog_input_out == ADCSQ_CH_OFF) [*2] |-> !analog_power_out)
    else $error("powered with channel off");
  AST_STOP: assert property (stop_mode_in [*5] |-> !analog_power_out && !sample_out)
    else $error("active in stop");
  AST_IRQ_RD: assert property (s_res_rd |-> ##2 !conv_irq_out)
    else $error("request kept after result read");
  AST_IRQ_WR: assert property (s_ctl_wr |-> ##2 !conv_irq_out)
    else $error("request kept after control write");
  AST_START: assert property (
    s_ctl_wr ##0 (reg_wdata_in[4:0] != ADCSQ_CH_OFF && !stop_mode_in)
    |-> ##[1:40] sample_out)
    else $error("no sample phase after start");
  AST_RST_CH: assert property ($fell(reset_in) |-> selected_analog_input_out == ADCSQ_RST_CH)
    else $error("channel not off after reset");
endmodule : adcsq_chk
bind adcsq_top adcsq_chk chk_i (.*);

// *** tb/adcsq_afe_model.sv ***
// analog front end: selected level compared with the trial code
// assumes one bench-set level on all pins; references are fixed
`timescale 1ns/1ps
module adcsq_afe_model
  import adcsq_pkg::*;
(
  // clock
  input  wire logic       clk_sys_in,
  // converter side
  input  wire logic [4:0] channel_in,
  input  wire logic [7:0] trial_in,
  input  wire logic       power_in,
  input  wire logic [7:0] pin_level_in,
  output logic            comparator_out
);
  logic       noise_r = 1'b0;
  logic [7:0] level;
  // unpowered comparator toggles, never a stale answer
  always_ff @(posedge clk_sys_in) begin
    noise_r <= ~noise_r;
  end
  assign level = (channel_in == ADCSQ_CH_REF_HIGH) ? ADCSQ_CODE_FULL :
                 (channel_in == ADCSQ_CH_REF_LOW) ? ADCSQ_CODE_ZERO : pin_level_in;
  assign comparator_out = power_in ? (level >= trial_in) : noise_r;
endmodule : adcsq_afe_model

// *** tb/adc_sequencer_control_tb.sv ***
// testbench: register driver with read queue, analog model, pin checks
// assumes adcsq_top with its checker bound, clock 100 MHz
`timescale 1ns/1ps
module adc_sequencer_control_tb;
  import adcsq_pkg::*;
  localparam logic [7:0] SC = ADCSQ_OFF_STATUS_CTRL;
  localparam logic [7:0] RS = ADCSQ_OFF_RESULT;
  logic        clk_sys_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [7:0]  reg_addr_in = 8'h00;
  logic [7:0]  reg_wdata_in = 8'h00;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [7:0]  reg_rdata_out;
  logic        crystal_clock_in;
  logic        stop_mode_in = 1'b0;
  logic        conv_irq_out;
  logic        comparator_in;
  logic [7:0]  trial_code_out;
  logic [4:0]  selected_analog_input_out;
  logic        sample_out;
  logic        analog_power_out;
  logic [14:0] port_data_latch_in = 15'h0000;
  logic [14:0] port_dir_in = 15'h0000;
  logic [14:0] port_pin_in = 15'h0000;
  logic [14:0] pin_takeover_out;
  logic [14:0] port_read_out;
  logic [7:0]  lvl = 8'h00;
  logic [7:0]  got;
  logic [7:0]  v;
  logic [15:0] e;
  logic [15:0] q[$];
  logic [14:0] tk;
  logic [4:0]  chn;
  logic        rd_d = 1'b0;
  logic [1:0]  xc = 2'h0;
  int          fail_count = 0;
  int          comparisons = 0;
  int          n;

  adcsq_top uut (.*);
  adcsq_afe_model afe (
    .clk_sys_in     (clk_sys_in),
    .channel_in     (selected_analog_input_out),
    .trial_in       (trial_code_out),
    .power_in       (analog_power_out),
    .pin_level_in   (lvl),
    .comparator_out (comparator_in)
  );
  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) xc <= xc + 2'h1;
  assign crystal_clock_in = xc[1];
  // oldest note matched to the data standing after each read
  always @(posedge clk_sys_in) begin
    if (rd_d) begin
      e = q.pop_front();
      if (e[15:8] != 8'h00) chk({7'h00, reg_rdata_out & e[15:8]}, {7'h00, e[7:0]});
    end
    rd_d <= reg_rd_in;
  end
  task automatic chk(input logic [14:0] g, input logic [14:0] x);
    comparisons++;
    if (g !== x) begin
      fail_count++;
      $display("MISMATCH %0t got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    reg_rd_in <= 1'b0;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
    q.push_back({m, x & m});
    reg_addr_in <= a;
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 got = reg_rdata_out;
  endtask : rd_reg
  task automatic idle(input int c);
    repeat (c) @(posedge clk_sys_in);
    #1;
  endtask : idle
  task automatic convert(input logic [4:0] c, input logic [7:0] lv, x, ctl);
    lvl <= lv;
    wr_reg(SC, ctl | {3'h0, c});
    for (n = 0; n < 400; n++) begin
      rd_reg(SC, 8'h00, 8'h00);
      if (got[ADCSQ_BIT_COMPLETE] === 1'b1) break;
    end
    if (n == 400) begin
      fail_count++;
      $display("MISMATCH %0t no completion", $time);
      close_out();
    end
    rd_reg(RS, 8'hFF, x);
  endtask : convert
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    void'($urandom(32'hDEB3));
    repeat (20) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    idle(1);
    rd_reg(SC, 8'hFF, 8'h1F);
    rd_reg(ADCSQ_OFF_CLOCK_CFG, 8'hFF, 8'h00);
    wr_reg(8'h3B, 8'hA5);
    rd_reg(8'h3B, 8'hFF, 8'h00);
    convert(ADCSQ_CH_REF_HIGH, 8'h00, 8'hFF, 8'h00);
    $display("test reset and crystal done");
    for (int d = 0; d < 5; d++) begin
      wr_reg(ADCSQ_OFF_CLOCK_CFG, {d[2:0], 5'h10});
      wr_reg(SC, 8'h1D);
      for (n = 0; n < 40 && sample_out !== 1'b1; n++) idle(1);
      for (n = 0; n < 300 && sample_out === 1'b1; n++) idle(1);
      chk(15'(n), 15'(((ADCSQ_CONV_CYCLES - 8) << d) + 1));
      v = trial_code_out;
      for (n = 0; n < 40 && trial_code_out === v; n++) idle(1);
      v = trial_code_out;
      for (n = 0; n < 40 && trial_code_out === v; n++) idle(1);
      chk(15'(n), 15'(1 << d));
    end
    wr_reg(ADCSQ_OFF_CLOCK_CFG, 8'h70);
    for (int k = 0; k < 8; k++) begin
      chn = (k == 0) ? ADCSQ_CH_REF_HIGH : (k == 1) ? ADCSQ_CH_REF_LOW : 5'($urandom_range(14));
      v = 8'($urandom);
      convert(chn, v, (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : v, 8'h00);
      rd_reg(SC, 8'h80, 8'h00);
      port_data_latch_in <= 15'($urandom);
      port_dir_in <= 15'($urandom);
      port_pin_in <= 15'($urandom);
      tk = (chn <= ADCSQ_CH_LAST) ? 15'h0001 << chn : 15'h0000;
      idle(4);
      chk(pin_takeover_out, tk);
      chk(port_read_out, (port_data_latch_in & port_dir_in & tk) | (port_pin_in & ~tk));
    end
    wr_reg(SC, 8'h03);
    idle(20);
    convert(ADCSQ_CH_REF_HIGH, 8'h00, 8'hFF, 8'h00);
    $display("test channels done");
    convert(5'h05, 8'h5A, 8'h5A, 8'h20);
    lvl <= 8'hA5;
    idle(250);
    rd_reg(SC, 8'hA0, 8'hA0);
    rd_reg(RS, 8'hFF, 8'hA5);
    convert(5'h05, 8'h3C, 8'h3C, 8'h00);
    idle(250);
    rd_reg(SC, 8'hA0, 8'h00);
    $display("test continuous done");
    wr_reg(SC, 8'h47);
    for (n = 0; n < 400 && conv_irq_out !== 1'b1; n++) idle(1);
    chk({14'h0, conv_irq_out}, 15'h0001);
    rd_reg(SC, 8'hE0, 8'h40);
    rd_reg(RS, 8'h00, 8'h00);
    idle(2);
    chk({14'h0, conv_irq_out}, 15'h0000);
    wr_reg(SC, 8'hC7);
    idle(250);
    chk({14'h0, conv_irq_out}, 15'h0000);
    wr_reg(SC, 8'h47);
    for (n = 0; n < 400 && conv_irq_out !== 1'b1; n++) idle(1);
    wr_reg(SC, 8'h1F);
    idle(3);
    chk({13'h0, conv_irq_out, analog_power_out}, 15'h0000);
    $display("test interrupt done");
    wr_reg(SC, 8'h02);
    idle(80);
    stop_mode_in <= 1'b1;
    idle(100);
    chk({14'h0, analog_power_out}, 15'h0000);
    stop_mode_in <= 1'b0;
    idle(130);
    rd_reg(SC, 8'h80, 8'h00);
    convert(5'h02, 8'h81, 8'h81, 8'h00);
    $display("test stop done");
    close_out();
  end
endmodule : adc_sequencer_control_tb
